//--- design/csdd_core.sv
/*
 * Sync hold-low / release sequencing for four output groups and coarse
 * digital delay on group four, with an Avalon-MM register slave.
 * Assumes clock is the distribution path at half-period resolution and
 * syncPin is asynchronous to it.
 */
// Decided for this implementation: the Avalon-MM slave port and the placing of the registers.

module csdd_core
    import csdd_pkg::*;
(
    // system
    input  wire logic              clock,
    input  wire logic              reset,
    // register bus
    input  wire logic [ADDR_W-1:0] address,
    input  wire logic              read,
    input  wire logic              write,
    input  wire logic [31:0]       writedata,
    input  wire logic [3:0]        byteenable,
    output logic      [31:0]       readdata,
    output logic                   waitrequest,
    // pins
    input  wire logic              syncPin,
    output logic      [13:0]       clockOut
);

    // ----------------------------------------------------------------
    // bus slave
    // ----------------------------------------------------------------
    logic        waitReq_reg;
    logic [31:0] readData_reg;
    csdd_ctrl_t  ctrl_reg;
    csdd_delay_t delay_reg;
    logic [3:0]  smallDiv_reg [3];
    logic [10:0] div4_reg;
    logic [9:0]  activeDelay_reg;
    logic        syncNow_reg;
    logic [3:0]  groupRun;
    logic [3:0]  groupClk;

    wire         request   = read | write;
    wire         accept    = request & ~waitReq_reg;
    wire [31:0]  writeMask = {{8{byteenable[3]}}, {8{byteenable[2]}},
                              {8{byteenable[1]}}, {8{byteenable[0]}}};
    wire         wrCtrl    = write & accept & (address == CTRL_OFS);
    wire         wrDelay   = write & accept & (address == DELAY_OFS);
    wire         wrDivide  = write & accept & (address == DIVIDE_OFS);

    wire [31:0]  ctrlWord   = {24'h0, ctrl_reg.syncExcludeGroup, 2'h0,
                               ctrl_reg.autoSyncEnable, ctrl_reg.syncPolarityInvert};
    wire [31:0]  delayWord  = {15'h0, delay_reg.halfStepSelect, 6'h0, delay_reg.coarseDelayCount};
    wire [31:0]  divideWord = {5'h0, div4_reg, 4'h0, smallDiv_reg[2], smallDiv_reg[1], smallDiv_reg[0]};
    wire [31:0]  statusWord = {6'h0, activeDelay_reg, 11'h0, syncNow_reg, groupRun};

    wire [31:0]  ctrlMerge   = (ctrlWord & ~writeMask) | (writedata & writeMask);
    wire [31:0]  delayMerge  = (delayWord & ~writeMask) | (writedata & writeMask);
    wire [31:0]  divideMerge = (divideWord & ~writeMask) | (writedata & writeMask);

    wire [31:0]  readMux = (address == CTRL_OFS)   ? ctrlWord   :
                           (address == DELAY_OFS)  ? delayWord  :
                           (address == DIVIDE_OFS) ? divideWord :
                           (address == STATUS_OFS) ? statusWord : 32'h0;

    assign waitrequest = waitReq_reg;
    assign readdata    = readData_reg;

    // one wait cycle per access; read data loaded while wait is still high
    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            waitReq_reg  <= 1'b1;
            readData_reg <= 32'h0;
        end
        else
        begin
            waitReq_reg <= ~(request & waitReq_reg);
            if (read & waitReq_reg)
            begin
                readData_reg <= readMux;
            end
        end
    end

    // reset gives undivided, unexcluded, minimum delay
    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            ctrl_reg        <= '0;
            delay_reg       <= {1'b0, DDLY_RESET};
            smallDiv_reg[0] <= SDIV_RESET;
            smallDiv_reg[1] <= SDIV_RESET;
            smallDiv_reg[2] <= SDIV_RESET;
            div4_reg        <= DIV4_RESET;
        end
        else
        begin
            if (wrCtrl)
            begin
                ctrl_reg <= {ctrlMerge[7:4], ctrlMerge[1:0]};
            end
            if (wrDelay)
            begin
                delay_reg <= {delayMerge[HS_BIT], delayMerge[9:0]};
            end
            if (wrDivide)
            begin
                smallDiv_reg[0] <= divideMerge[3:0];
                smallDiv_reg[1] <= divideMerge[7:4];
                smallDiv_reg[2] <= divideMerge[11:8];
                div4_reg        <= divideMerge[DIV4_LSB+10:DIV4_LSB];
            end
        end
    end

    // ----------------------------------------------------------------
    // effective settings
    // ----------------------------------------------------------------
    function automatic logic [3:0] smallEff(input logic [3:0] v);
        smallEff = (v == 4'h0) ? 4'h1 : ((v > SDIV_MAX) ? SDIV_MAX : v);
    endfunction

    wire [10:0] div4Eff = (div4_reg == 11'h0) ? 11'h001 :
                          ((div4_reg > DIV4_MAX) ? DIV4_MAX : div4_reg);
    wire [9:0]  countEff = (delay_reg.coarseDelayCount < DDLY_MIN) ? DDLY_MIN :
                           ((delay_reg.coarseDelayCount > DDLY_MAX) ? DDLY_MAX :
                            delay_reg.coarseDelayCount);
    wire        hsLive   = delay_reg.halfStepSelect;

    // ----------------------------------------------------------------
    // sync sources
    // ----------------------------------------------------------------
    logic       pinMeta_reg;
    logic       pinSync_reg;
    logic       syncPrev_reg;
    logic [4:0] autoWait_reg;
    logic [4:0] autoHold_reg;
    logic       autoAll_reg;
    logic [3:0] part_reg;
    logic       hsPrev_reg;

    // polarity toggle flips manualReq just as the pin would
    wire        manualReq = pinSync_reg ^ ctrl_reg.syncPolarityInvert;
    wire        autoStart = ctrl_reg.autoSyncEnable & (wrDelay | wrDivide);
    wire        autoReq   = autoHold_reg != 5'h0;
    wire        syncReq   = manualReq | autoReq;
    wire        assertEv  = syncNow_reg & ~syncPrev_reg;
    wire        releaseEv = ~syncNow_reg & syncPrev_reg;
    // bank A is groups 0 and 1, bank B groups 2 and 3
    wire [3:0]  bankSel   = (manualReq | autoAll_reg) ? 4'hF : 4'hC;
    wire [3:0]  joinNow   = bankSel & ~ctrl_reg.syncExcludeGroup;
    wire        hsRose    = hsLive & ~hsPrev_reg;
    wire        hsFell    = ~hsLive & hsPrev_reg;

    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            pinMeta_reg  <= 1'b0;
            pinSync_reg  <= 1'b0;
            syncNow_reg  <= 1'b0;
            syncPrev_reg <= 1'b0;
            hsPrev_reg   <= 1'b0;
        end
        else
        begin
            pinMeta_reg  <= syncPin;
            pinSync_reg  <= pinMeta_reg;
            syncNow_reg  <= syncReq;
            syncPrev_reg <= syncNow_reg;
            hsPrev_reg   <= hsLive;
        end
    end

    // auto sync: wait out the strobe-to-event delay, then hold long enough to register
    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            autoWait_reg <= 5'h0;
            autoHold_reg <= 5'h0;
            autoAll_reg  <= 1'b0;
        end
        else
        begin
            if (autoStart)
            begin
                autoWait_reg <= AUTO_SYNC_CYCLES;
                autoAll_reg  <= wrDivide | (autoAll_reg & autoReq);
            end
            else if (autoWait_reg != 5'h0)
            begin
                autoWait_reg <= autoWait_reg - 5'h1;
            end
            if (autoWait_reg == 5'h1 && !autoStart)
            begin
                autoHold_reg <= AUTO_HOLD_CYCLES;
            end
            else if (autoReq)
            begin
                autoHold_reg <= autoHold_reg - 5'h1;
            end
        end
    end

    // delay count only moves at an including sync; excluded groups keep their phase
    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            activeDelay_reg <= DDLY_RESET;
            part_reg        <= 4'h0;
        end
        else if (assertEv)
        begin
            part_reg <= joinNow;
            if (joinNow[3])
            begin
                activeDelay_reg <= countEff;
            end
        end
    end

    // ----------------------------------------------------------------
    // output groups
    // ----------------------------------------------------------------
    for (genvar g = 0; g < 4; g++)
    begin : grp
        logic [10:0] stopCnt_reg;
        logic        stopping_reg;
        logic [10:0] startCnt_reg;
        logic        starting_reg;
        logic        run_reg;
        logic [11:0] phase_reg;
        logic        clk_reg;

        wire  [10:0] divG  = (g == 3) ? div4Eff : {7'h0, smallEff(smallDiv_reg[g % 3])};
        wire         div1  = divG == 11'h001;
        wire  [10:0] lowT  = (g == 3) ? (div1 ? LOW_D1 : LOW_DN) : LOW_ABC;
        // group four: delay in half periods minus half step, plus base latency
        wire  [10:0] riseT = (g == 3) ?
                             11'({activeDelay_reg, 1'b0} - {10'h0, hsLive}) + (div1 ? RISE_D1 : RISE_DN) :
                             RISE_ABC;
        wire  [11:0] span  = {divG, 1'b0};
        // half-step rise skips one tick (half period earlier, as at a sync), fall pauses one
        wire  [11:0] step  = (g == 3 && hsRose) ? 12'h2 : ((g == 3 && hsFell) ? 12'h0 : 12'h1);
        wire  [11:0] sum   = phase_reg + step;
        wire  [11:0] pNext = (sum >= span) ? sum - span : sum;

        always_ff @(posedge clock)
        begin
            if (reset)
            begin
                stopping_reg <= 1'b0;
                stopCnt_reg  <= 11'h0;
            end
            else if (assertEv && joinNow[g])
            begin
                stopping_reg <= 1'b1;
                // two short: the registering edge and the output flop each cost a tick
                stopCnt_reg  <= lowT - 11'h2;
            end
            else if (stopping_reg)
            begin
                stopping_reg <= stopCnt_reg != 11'h0;
                stopCnt_reg  <= stopCnt_reg - 11'h1;
            end
        end

        always_ff @(posedge clock)
        begin
            if (reset)
            begin
                starting_reg <= 1'b0;
                startCnt_reg <= 11'h0;
            end
            else if (releaseEv && part_reg[g])
            begin
                starting_reg <= 1'b1;
                startCnt_reg <= riseT - 11'h2;
            end
            else if (starting_reg)
            begin
                starting_reg <= startCnt_reg != 11'h0;
                startCnt_reg <= startCnt_reg - 11'h1;
            end
        end

        // forcing low is not aligned to the divided clock, so a runt can appear
        always_ff @(posedge clock)
        begin
            if (reset)
            begin
                run_reg   <= 1'b1;
                phase_reg <= 12'h0;
                clk_reg   <= 1'b1;
            end
            else if (starting_reg && startCnt_reg == 11'h0)
            begin
                run_reg   <= 1'b1;
                phase_reg <= 12'h0;
                clk_reg   <= 1'b1;
            end
            else if (stopping_reg && stopCnt_reg == 11'h0)
            begin
                run_reg <= 1'b0;
                clk_reg <= 1'b0;
            end
            else if (run_reg)
            begin
                phase_reg <= pNext;
                clk_reg   <= pNext < {1'b0, divG};
            end
        end

        assign groupClk[g] = clk_reg;
        assign groupRun[g] = run_reg;
    end

    // one divider feeds both group-four outputs
    assign clockOut = {{2{groupClk[3]}}, {4{groupClk[2]}}, {4{groupClk[1]}}, {4{groupClk[0]}}};

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    sync_polarity_a: assert property (@(posedge clock) disable iff (reset)
        (pinSync_reg != ctrl_reg.syncPolarityInvert) |=> syncNow_reg)
        else $error("sync level mismatch not registered");

    bus_answer_a: assert property (@(posedge clock) disable iff (reset)
        (request && waitrequest) |=> !waitrequest)
        else $error("bus access not answered in one cycle");

    delay_hold_a: assert property (@(posedge clock) disable iff (reset)
        !assertEv |=> $stable(activeDelay_reg))
        else $error("coarse delay changed without sync");

    delay_take_a: assert property (@(posedge clock) disable iff (reset)
        (assertEv && joinNow[3]) |=> (activeDelay_reg == $past(countEff)))
        else $error("coarse delay not taken at sync");

    delay_range_a: assert property (@(posedge clock) disable iff (reset)
        (activeDelay_reg >= DDLY_MIN) && (activeDelay_reg <= DDLY_MAX))
        else $error("coarse delay out of range");

    group_low_a: assert property (@(posedge clock) disable iff (reset)
        (assertEv && joinNow[0]) |-> ##9 !groupClk[0])
        else $error("group one not low 4.5 periods after sync");

    group_rise_a: assert property (@(posedge clock) disable iff (reset)
        (releaseEv && part_reg[0]) |-> !groupClk[0] [*8] ##1 !groupClk[0] [*2] ##1 groupClk[0])
        else $error("group one did not rise 5 periods after release");

    four_low_a: assert property (@(posedge clock) disable iff (reset)
        (assertEv && joinNow[3] && div4Eff == 11'h001) |-> ##11 !groupClk[3])
        else $error("group four not low 5.5 periods after sync");

    exclude_run_a: assert property (@(posedge clock) disable iff (reset)
        (assertEv && ctrl_reg.syncExcludeGroup[1]) |=> !part_reg[1] ##[0:20] groupRun[1])
        else $error("excluded group joined sync");

    half_step_a: assert property (@(posedge clock) disable iff (reset)
        wrDelay |=> (hsLive == $past(delayMerge[HS_BIT])))
        else $error("half step not applied at once");

    auto_sync_a: assert property (@(posedge clock) disable iff (reset)
        (autoStart && !syncReq) |-> !autoReq [*8] ##1 !autoReq [*2] ##1 autoReq)
        else $error("auto sync not raised after strobe delay");

endmodule

//--- design/csdd_pkg.sv
/*
 * Constants, register map and carrier types for the sync and coarse
 * digital delay block of a four-group clock divider.
 * Assumes one clock tick of the block equals half a distribution-path period.
 */
package csdd_pkg;

    // ----------------------------------------------------------------
    // register map (byte addresses, one word each)
    // ----------------------------------------------------------------
    localparam int          ADDR_W     = 5;
    localparam logic [4:0]  CTRL_OFS   = 5'h00;
    localparam logic [4:0]  DELAY_OFS  = 5'h04;
    localparam logic [4:0]  DIVIDE_OFS = 5'h08;
    localparam logic [4:0]  STATUS_OFS = 5'h0C;

    // ----------------------------------------------------------------
    // field positions and reset values
    // ----------------------------------------------------------------
    localparam int          HS_BIT     = 16;
    localparam int          DIV4_LSB   = 16;
    localparam logic [9:0]  DDLY_MIN   = 10'h005;
    localparam logic [9:0]  DDLY_MAX   = 10'h20A;
    localparam logic [9:0]  DDLY_RESET = 10'h005;
    localparam logic [3:0]  SDIV_MAX   = 4'h8;
    localparam logic [3:0]  SDIV_RESET = 4'h1;
    localparam logic [10:0] DIV4_MAX   = 11'h415;
    localparam logic [10:0] DIV4_RESET = 11'h001;

    // ----------------------------------------------------------------
    // latencies in half-period ticks
    // ----------------------------------------------------------------
    localparam logic [10:0] LOW_ABC  = 11'h009;
    localparam logic [10:0] LOW_D1   = 11'h00B;
    localparam logic [10:0] LOW_DN   = 11'h00D;
    localparam logic [10:0] RISE_ABC = 11'h00A;
    localparam logic [10:0] RISE_D1  = 11'h00A;
    localparam logic [10:0] RISE_DN  = 11'h00C;

    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam int         CLOCK_PERIOD_NS  = 20;
    localparam int         AUTO_SYNC_NS     = 170;
    localparam logic [4:0] AUTO_SYNC_CYCLES =
        5'((AUTO_SYNC_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS);
    localparam logic [4:0] AUTO_HOLD_CYCLES = 5'h10;

    // ----------------------------------------------------------------
    // carriers
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [3:0] syncExcludeGroup;
        logic       autoSyncEnable;
        logic       syncPolarityInvert;
    } csdd_ctrl_t;

    typedef struct packed {
        logic       halfStepSelect;
        logic [9:0] coarseDelayCount;
    } csdd_delay_t;

endpackage

//--- test/csdd_host.sv
/*
 * Host model on the sync pin: turns a one-cycle request into a held level.
 * Assumes the bench pulses syncReq for one clock and sets polarityInvert
 * to match what it wrote into the control register.
 */
module csdd_host
(
    // system
    input  wire logic clock,
    // requests
    input  wire logic syncReq,
    input  wire logic polarityInvert,
    // pin
    output logic      syncPin
);
    timeunit 1ns;
    timeprecision 1ns;

    logic [4:0] holdCount = 5'h00;

    // a short pulse may slip past the synchronizer, so hold it long
    always_ff @(posedge clock)
    begin
        if (syncReq)
            holdCount <= 5'h10;
        else if (holdCount != 5'h00)
            holdCount <= holdCount - 5'h01;
    end

    assign syncPin = (holdCount != 5'h00) ^ polarityInvert;
endmodule

//--- test/csdd_core_tb.sv
/*
 * Self-checking bench for csdd_core: bus master tasks, host model on the pin.
 * Assumes the register map and tick latencies declared in csdd_pkg.
 */
module csdd_core_tb
    import csdd_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    logic              clock;
    logic              reset;
    logic [ADDR_W-1:0] address;
    logic              read;
    logic              write;
    logic [31:0]       writedata;
    logic [3:0]        byteenable;
    logic [31:0]       readdata;
    logic              waitrequest;
    logic              syncPin;
    logic              syncReq;
    logic              hostInvert;
    logic [13:0]       clockOut;
    int                errCount;
    int                numChecks;

    csdd_core DUT (.clock(clock), .reset(reset), .address(address), .read(read), .write(write),
        .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
        .waitrequest(waitrequest), .syncPin(syncPin), .clockOut(clockOut));
    csdd_host host (.clock(clock), .syncReq(syncReq), .polarityInvert(hostInvert), .syncPin(syncPin));

    initial
    begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end

    // ----------------------------------------------------------------
    // shared tasks
    // ----------------------------------------------------------------
    task automatic test_done();
        if (errCount == 0 && numChecks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        numChecks++;
        if (got !== exp)
        begin
            errCount++;
            $display("BAD %s expected %0h seen %0h", name, exp, got);
        end
    endtask

    task automatic timeout();
        errCount++;
        $display("BAD wait expected done seen timeout");
        test_done();
    endtask

    task automatic bus(input logic we, input logic [4:0] a, input logic [31:0] d,
                       input logic [3:0] be, output logic [31:0] rd);
        int i;
        i = 0;
        @(posedge clock);
        address <= a;
        writedata <= d;
        byteenable <= be;
        read <= !we;
        write <= we;
        do
        begin
            @(posedge clock);
            i++;
        end
        while (waitrequest !== 1'b0 && i < 20);
        if (waitrequest !== 1'b0)
            timeout();
        rd = readdata;
        read <= 1'b0;
        write <= 1'b0;
    endtask

    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        logic [31:0] rd;
        bus(1'b1, a, d, 4'hF, rd);
    endtask

    task automatic pulse();
        @(posedge clock);
        syncReq <= 1'b1;
        @(posedge clock);
        syncReq <= 1'b0;
    endtask

    // four lows in a row, since a toggling output is low every other tick
    task automatic wait_held(input logic [13:0] mask, output int t);
        int run;
        run = 0;
        t = 0;
        while (run < 4)
        begin
            @(negedge clock);
            t++;
            run = ((clockOut & mask) === 14'h0000) ? run + 1 : 0;
            if (t > 80)
                timeout();
        end
    endtask

    task automatic lag_check(input int exp, input bit bankA);
        int n;
        int t0;
        int t8;
        int t12;
        t0 = -1;
        t8 = -1;
        t12 = -1;
        for (n = 0; n < 1300 && t12 < 0; n++)
        begin
            @(negedge clock);
            if (clockOut[0] === 1'b1 && t0 < 0) t0 = n;
            if (clockOut[8] === 1'b1 && t8 < 0) t8 = n;
            if (clockOut[12] === 1'b1 && t12 < 0) t12 = n;
        end
        if (bankA)
            check("group rise", t8, t0);
        else
            check("bank a free", 32'h1, {31'h0, t0 <= 1});
        check("group four lag", exp, t12 - t8);
    endtask

    task automatic sync_lag(input int exp);
        int t;
        pulse();
        wait_held(14'h3FFF, t);
        lag_check(exp, 1'b1);
    endtask

    always @(negedge clock)
        if (!reset && clockOut[12] !== clockOut[13])
            check("pair match", clockOut[12], clockOut[13]);

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic test_reset();
        logic [31:0] r;
        @(negedge clock);
        r = {18'h0, clockOut};
        @(negedge clock);
        check("bypass toggle", {18'h0, ~r[13:0]}, {18'h0, clockOut});
        bus(1'b0, CTRL_OFS, 32'h0, 4'hF, r);
        check("ctrl reset", 32'h0, r);
        bus(1'b0, DELAY_OFS, 32'h0, 4'hF, r);
        check("delay reset", {22'h0, DDLY_RESET}, r);
        bus(1'b1, DIVIDE_OFS, 32'hFFFF_FFFF, 4'h0, r);
        bus(1'b0, DIVIDE_OFS, 32'h0, 4'hF, r);
        check("divide reset", {5'h0, DIV4_RESET, 4'h0, SDIV_RESET, SDIV_RESET, SDIV_RESET}, r);
        bus(1'b0, 5'h10, 32'h0, 4'hF, r);
        check("unmapped", 32'h0, r);
    endtask

    task automatic test_delay();
        sync_lag(10);
        wr(DELAY_OFS, 32'h7);
        sync_lag(14);
        wr(DELAY_OFS, {22'h0, DDLY_MAX});
        sync_lag(1044);
        wr(DELAY_OFS, 32'h3);
        sync_lag(10);
    endtask

    task automatic test_exclude();
        int t;
        logic s;
        logic s1;
        logic [31:0] r;
        wr(CTRL_OFS, 32'hA0);
        wr(DELAY_OFS, 32'h9);
        pulse();
        wait_held(14'h0F0F, t);
        s = clockOut[12];
        s1 = clockOut[4];
        @(negedge clock);
        check("excluded runs", {31'h0, ~s}, {31'h0, clockOut[12]});
        check("excluded pair", {31'h0, ~s1}, {31'h0, clockOut[4]});
        bus(1'b0, STATUS_OFS, 32'h0, 4'hF, r);
        check("kept delay", {6'h0, DDLY_MIN, 11'h0, 1'b1, 4'hA}, r);
        wr(CTRL_OFS, 32'h0);
        sync_lag(18);
    endtask

    task automatic test_half();
        @(negedge clock);
        check("even phase", {31'h0, clockOut[8]}, {31'h0, clockOut[12]});
        wr(DELAY_OFS, 32'h0001_0005);
        @(negedge clock);
        @(negedge clock);
        check("half step now", {31'h0, ~clockOut[8]}, {31'h0, clockOut[12]});
        sync_lag(9);
        wr(DELAY_OFS, 32'h5);
        wr(DIVIDE_OFS, 32'h0002_0111);
        sync_lag(12);
        wr(DIVIDE_OFS, 32'h0001_0111);
        sync_lag(10);
    endtask

    task automatic test_polarity();
        int t;
        wr(CTRL_OFS, 32'h1);
        wait_held(14'h3FFF, t);
        wait_held(14'h3FFF, t);
        @(posedge clock);
        hostInvert <= 1'b1;
        lag_check(10, 1'b1);
        wr(CTRL_OFS, 32'h0);
        wait_held(14'h3FFF, t);
        @(posedge clock);
        hostInvert <= 1'b0;
        lag_check(10, 1'b1);
        sync_lag(10);
    endtask

    task automatic test_auto();
        int t;
        logic s;
        wr(CTRL_OFS, 32'h2);
        wr(DELAY_OFS, 32'h5);
        wait_held(14'h3F00, t);
        check("auto delay wait", 32'h1, {31'h0, t > 9});
        s = clockOut[0];
        @(negedge clock);
        check("bank a runs", {31'h0, ~s}, {31'h0, clockOut[0]});
        lag_check(10, 1'b0);
        wr(DIVIDE_OFS, 32'h0001_0111);
        wait_held(14'h3FFF, t);
        check("auto both wait", 32'h1, {31'h0, t > 9});
        lag_check(10, 1'b1);
        wr(CTRL_OFS, 32'h0);
    endtask

    initial
    begin
        reset = 1'b1;
        address = '0;
        read = 1'b0;
        write = 1'b0;
        writedata = 32'h0;
        byteenable = 4'hF;
        syncReq = 1'b0;
        hostInvert = 1'b0;
        errCount = 0;
        numChecks = 0;
        repeat (2) @(posedge clock);
        reset <= 1'b0;
        test_reset();
        test_delay();
        test_exclude();
        test_half();
        test_polarity();
        test_auto();
        test_done();
    end
endmodule
